/* File: lvdsoc_pkg.sv */
package lvdsoc_pkg;

  localparam int          ADDR_W              = 12;
  localparam int          DATA_W              = 8;
  localparam int          SAMPLE_W            = 12;
  localparam int          PATTERN_LEN         = 8;

  localparam logic [11:0] PATTERN_CONTROL_OFS = 12'h0190;
  localparam logic [11:0] OUT_IF_ENABLE_OFS   = 12'h0200;
  localparam logic [11:0] OUT_IF_MODE_OFS     = 12'h0201;

  localparam logic [7:0]  PATTERN_CONTROL_RST = 8'h1e;
  localparam logic [7:0]  OUT_IF_ENABLE_RST   = 8'h01;
  localparam logic [7:0]  OUT_IF_MODE_RST     = 8'h01;

  // Pattern control fields
  localparam int          INV_A_BIT           = 0;
  localparam int          INV_B_BIT           = 1;
  localparam int          INV_C_BIT           = 2;
  localparam int          INV_D_BIT           = 3;
  localparam int          FIXED_LANE_BIT      = 4;
  // Bit of the sample flipped by each bus inversion
  localparam int          INV_A_POS           = 8;
  localparam int          INV_B_POS           = 9;
  localparam int          INV_C_POS           = 10;
  localparam int          INV_D_POS           = 11;

  // Enable field
  localparam int          ENABLE_BIT          = 0;

  // Mode fields
  localparam int          DEMUX_BIT           = 0;
  localparam int          ALIGN_BIT           = 1;
  localparam int          INTERLEAVE_BIT      = 2;
  localparam int          WIDTH_LSB           = 4;

  localparam logic [1:0]  WIDTH_12            = 2'h0;
  localparam logic [1:0]  WIDTH_11            = 2'h1;
  localparam logic [1:0]  WIDTH_10            = 2'h2;
  localparam logic [1:0]  WIDTH_8             = 2'h3;

  localparam logic [11:0] LANE_LO             = 12'h0000;
  localparam logic [11:0] LANE_HI             = 12'h0fff;
  // Fixed lane pattern, one bit per sample index: 0,1,0,0,0,1,1,1
  localparam logic [7:0]  FIXED_LANE_BITS     = 8'he2;

  // Frame length in UIs (fixed here, a multiple of 4)
  localparam logic [7:0]  FRAME_UIS           = 8'h80;

  typedef enum logic [1:0] {
    LVDSOC_OFF,
    LVDSOC_WAIT,
    LVDSOC_RUN
  } lvdsoc_state_t;

endpackage

/* File: lvdsoc_regs.sv */
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module lvdsoc_regs
  import lvdsoc_pkg::*;
(
  input  wire logic                i_mclk,            // System clock, 20 MHz
  input  wire logic                i_reset_n,         // Async reset, active low
  input  wire logic [ADDR_W-1:0]   i_addr,            // Register address
  input  wire logic [DATA_W-1:0]   i_wdata,           // Write data
  input  wire logic                i_wr,              // Write strobe
  input  wire logic                i_rd,              // Read strobe
  output logic      [DATA_W-1:0]   o_rdata,           // Read data, cycle after strobe
  input  wire logic                i_link_clk,        // Output clock, foreign domain
  input  wire logic                i_sysref,          // SYSREF, foreign domain
  input  wire logic                i_user_test_pattern_select,    // Test pattern select picks user pattern
  input  wire logic [8*SAMPLE_W-1:0] i_user_pattern_sample, // Eight user samples, 0 low
  input  wire logic [SAMPLE_W-1:0] i_sample_ch0,      // Converter channel 0 sample
  input  wire logic [SAMPLE_W-1:0] i_sample_ch1,      // Converter channel 1 sample
  output logic      [SAMPLE_W-1:0] o_bus_a,           // Bus A data
  output logic      [SAMPLE_W-1:0] o_bus_b,           // Bus B data
  output logic      [SAMPLE_W-1:0] o_bus_c,           // Bus C data
  output logic      [SAMPLE_W-1:0] o_bus_d,           // Bus D data
  output logic      [3:0]          o_bus_active,      // Powered buses, D..A
  output logic                     o_strobe,          // Frame start strobe
  output logic                     o_clk_enable,      // Interface clock gate open
  output logic                     o_single_channel   // Interleaved mode in force
);

  logic [7:0]          pat_ctrl_reg;
  logic [7:0]          enable_reg;
  logic [7:0]          mode_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic [2:0]          link_sync_reg;
  logic [2:0]          sysref_sync_reg;
  lvdsoc_state_t       state_reg;
  logic                ui_phase_reg;
  logic [7:0]          frame_cnt_reg;
  logic [2:0]          pat_idx_reg;
  logic [SAMPLE_W-1:0] bus_a_reg;
  logic [SAMPLE_W-1:0] bus_b_reg;
  logic [SAMPLE_W-1:0] bus_c_reg;
  logic [SAMPLE_W-1:0] bus_d_reg;
  logic [SAMPLE_W-1:0] hold_c_reg;
  logic [SAMPLE_W-1:0] hold_d_reg;
  logic                strobe_reg;

  logic                if_enable;
  logic                demux2;
  logic                aligned;
  logic                interleave;
  logic [1:0]          width_sel;
  logic                link_edge;
  logic                sysref_edge;
  logic                ui_tick;
  logic [2:0]          pat_idx_odd;
  logic [SAMPLE_W-1:0] src_even_a;
  logic [SAMPLE_W-1:0] src_even_b;
  logic [SAMPLE_W-1:0] src_odd_a;
  logic [SAMPLE_W-1:0] src_odd_b;
  logic [SAMPLE_W-1:0] next_a;
  logic [SAMPLE_W-1:0] next_b;
  logic [SAMPLE_W-1:0] next_c;
  logic [SAMPLE_W-1:0] next_d;

  // Pattern sample at an index, fixed lane pattern or user samples
  function automatic logic [SAMPLE_W-1:0] pattern_at(
    input logic [2:0]            idx,
    input logic                  fixed_lane,
    input logic [8*SAMPLE_W-1:0] user
  );
    logic [SAMPLE_W-1:0] s;
    s = user[idx*SAMPLE_W +: SAMPLE_W];
    if (fixed_lane) begin
      s = FIXED_LANE_BITS[idx] ? LANE_HI : LANE_LO;
    end
    return s;
  endfunction

  // Flip one bit of a pattern sample when that bus's inversion is set
  function automatic logic [SAMPLE_W-1:0] invert_bit(
    input logic [SAMPLE_W-1:0] s,
    input logic                inv,
    input int                  pos
  );
    logic [SAMPLE_W-1:0] r;
    r = s;
    if (inv) begin
      r[pos] = ~s[pos];
    end
    return r;
  endfunction

  // Reduce a sample to the selected width, unused low bits zero
  function automatic logic [SAMPLE_W-1:0] width_mask(
    input logic [SAMPLE_W-1:0] s,
    input logic [1:0]          sel
  );
    logic [SAMPLE_W-1:0] r;
    r = s;
    case (sel)
      WIDTH_12: r = s;
      WIDTH_11: r = {s[SAMPLE_W-1:1], 1'b0};
      WIDTH_10: r = {s[SAMPLE_W-1:2], 2'b00};
      WIDTH_8:  r = {s[SAMPLE_W-1:4], 4'h0};
      default:  r = s;
    endcase
    return r;
  endfunction

  assign if_enable  = enable_reg[ENABLE_BIT];
  assign demux2     = mode_reg[DEMUX_BIT];
  assign aligned    = mode_reg[ALIGN_BIT];
  assign interleave = mode_reg[INTERLEAVE_BIT];
  assign width_sel  = mode_reg[WIDTH_LSB +: 2];

  // Register writes
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pat_ctrl_reg <= PATTERN_CONTROL_RST;
      enable_reg   <= OUT_IF_ENABLE_RST;
      mode_reg     <= OUT_IF_MODE_RST;
    end else if (i_wr) begin
      if (i_addr == PATTERN_CONTROL_OFS) begin
        pat_ctrl_reg <= i_wdata;
      end else if (i_addr == OUT_IF_ENABLE_OFS) begin
        enable_reg <= i_wdata;
      end else if (i_addr == OUT_IF_MODE_OFS) begin
        mode_reg <= i_wdata;
      end
    end
  end

  // Register reads, data in the following cycle only
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg <= '0;
    end else if (i_rd) begin
      if (i_addr == PATTERN_CONTROL_OFS) begin
        rdata_reg <= pat_ctrl_reg;
      end else if (i_addr == OUT_IF_ENABLE_OFS) begin
        rdata_reg <= enable_reg;
      end else if (i_addr == OUT_IF_MODE_OFS) begin
        rdata_reg <= mode_reg;
      end else begin
        rdata_reg <= '0;
      end
    end else begin
      rdata_reg <= '0;
    end
  end

  assign o_rdata = rdata_reg;

  // Synchronise the link clock and SYSREF; stage 0 feeds stage 1 only
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_sync_reg   <= '0;
      sysref_sync_reg <= '0;
    end else begin
      link_sync_reg   <= {link_sync_reg[1:0], i_link_clk};
      sysref_sync_reg <= {sysref_sync_reg[1:0], i_sysref};
    end
  end

  assign link_edge   = link_sync_reg[1] & ~link_sync_reg[2];
  assign sysref_edge = sysref_sync_reg[1] & ~sysref_sync_reg[2];

  // Interface sequencer: off while disabled, wait for first link edge
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= LVDSOC_OFF;
    end else if (!if_enable) begin
      state_reg <= LVDSOC_OFF;
    end else begin
      case (state_reg)
        LVDSOC_OFF:  state_reg <= LVDSOC_WAIT;
        LVDSOC_WAIT: if (link_edge) begin
          state_reg <= LVDSOC_RUN;
        end
        LVDSOC_RUN:  state_reg <= LVDSOC_RUN;
        default:     state_reg <= LVDSOC_OFF;
      endcase
    end
  end

  // A UI spans one link cycle, or two with demux by 2
  assign ui_tick = link_edge && (state_reg == LVDSOC_RUN) &&
                   (!demux2 || ui_phase_reg);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ui_phase_reg <= 1'b0;
    end else if (state_reg != LVDSOC_RUN) begin
      ui_phase_reg <= 1'b0;
    end else if (link_edge) begin
      ui_phase_reg <= demux2 ? ~ui_phase_reg : 1'b0;
    end
  end

  // Frame counter, held in reset while disabled so SYSREF cannot align it
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      frame_cnt_reg <= '0;
      strobe_reg    <= 1'b0;
    end else if (state_reg == LVDSOC_OFF) begin
      frame_cnt_reg <= '0;
      strobe_reg    <= 1'b0;
    end else if (sysref_edge) begin
      frame_cnt_reg <= '0;
      strobe_reg    <= 1'b0;
    end else if (ui_tick) begin
      strobe_reg <= (frame_cnt_reg == 8'h00);
      if (frame_cnt_reg == FRAME_UIS - 8'h01) begin
        frame_cnt_reg <= '0;
      end else begin
        frame_cnt_reg <= frame_cnt_reg + 8'h01;
      end
    end
  end

  // Pattern index steps one sample per bus pair per UI
  assign pat_idx_odd = pat_idx_reg + 3'h1;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pat_idx_reg <= '0;
    end else if (state_reg == LVDSOC_OFF) begin
      pat_idx_reg <= '0;
    end else if (ui_tick) begin
      pat_idx_reg <= demux2 ? pat_idx_reg + 3'h2 : pat_idx_reg + 3'h1;
    end
  end

  // Source per bus: user pattern or converter channels
  always_comb begin
    src_even_a = pattern_at(pat_idx_reg, pat_ctrl_reg[FIXED_LANE_BIT],
                            i_user_pattern_sample);
    src_odd_a  = pattern_at(pat_idx_odd, pat_ctrl_reg[FIXED_LANE_BIT],
                            i_user_pattern_sample);
    src_even_b = src_even_a;
    src_odd_b  = src_odd_a;
    if (!i_user_test_pattern_select) begin
      src_even_a = i_sample_ch0;
      src_odd_a  = i_sample_ch0;
      src_even_b = interleave ? i_sample_ch0 : i_sample_ch1;
      src_odd_b  = src_even_b;
    end
  end

  always_comb begin
    next_a = src_even_a;
    next_b = src_even_b;
    next_c = src_odd_a;
    next_d = src_odd_b;
    if (i_user_test_pattern_select) begin
      next_a = invert_bit(src_even_a, pat_ctrl_reg[INV_A_BIT], INV_A_POS);
      next_b = invert_bit(src_even_b, pat_ctrl_reg[INV_B_BIT], INV_B_POS);
      next_c = invert_bit(src_odd_a, pat_ctrl_reg[INV_C_BIT], INV_C_POS);
      next_d = invert_bit(src_odd_b, pat_ctrl_reg[INV_D_BIT], INV_D_POS);
    end
  end

  // Output buses; staggered mode delays C and D by one UI
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bus_a_reg  <= '0;
      bus_b_reg  <= '0;
      bus_c_reg  <= '0;
      bus_d_reg  <= '0;
      hold_c_reg <= '0;
      hold_d_reg <= '0;
    end else if (state_reg == LVDSOC_OFF) begin
      bus_a_reg  <= '0;
      bus_b_reg  <= '0;
      bus_c_reg  <= '0;
      bus_d_reg  <= '0;
      hold_c_reg <= '0;
      hold_d_reg <= '0;
    end else if (ui_tick) begin
      bus_a_reg  <= width_mask(next_a, width_sel);
      bus_b_reg  <= width_mask(next_b, width_sel);
      hold_c_reg <= demux2 ? width_mask(next_c, width_sel) : '0;
      hold_d_reg <= demux2 ? width_mask(next_d, width_sel) : '0;
      if (aligned) begin
        bus_c_reg <= demux2 ? width_mask(next_c, width_sel) : '0;
        bus_d_reg <= demux2 ? width_mask(next_d, width_sel) : '0;
      end else begin
        bus_c_reg <= hold_c_reg;
        bus_d_reg <= hold_d_reg;
      end
    end
  end

  assign o_bus_a          = bus_a_reg;
  assign o_bus_b          = bus_b_reg;
  assign o_bus_c          = bus_c_reg;
  assign o_bus_d          = bus_d_reg;
  assign o_strobe         = strobe_reg;
  assign o_clk_enable     = (state_reg != LVDSOC_OFF);
  assign o_bus_active     = (state_reg == LVDSOC_OFF) ? 4'h0 :
                            (demux2 ? 4'hf : 4'h3);
  assign o_single_channel = interleave;

endmodule

`default_nettype wire

/* File: lvdsoc_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lvdsoc_rx_model (
  input  wire logic i_run,        // Link clock runs while high
  input  wire logic i_sysref_req, // Ask for an alignment pulse
  output logic      o_link_clk,   // Link clock, 400 ns period
  output logic      o_sysref      // Alignment pulse
);
  logic clk_q = 1'b0;
  logic sref_q = 1'b0;

  // Clock stands still low while the link is idle
  always #200 clk_q = i_run ? ~clk_q : 1'b0;
  always @(posedge clk_q) sref_q <= i_sysref_req;
  assign o_link_clk = clk_q;
  assign o_sysref = sref_q;
endmodule
`default_nettype wire

/* File: lvdsoc_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module lvdsoc_regs_assertions
  import lvdsoc_pkg::*;
(
  input wire logic                i_mclk,           // Clock
  input wire logic                i_reset_n,        // Reset
  input wire logic [ADDR_W-1:0]   i_addr,           // Address
  input wire logic [DATA_W-1:0]   i_wdata,          // Write data
  input wire logic                i_wr,             // Write strobe
  input wire logic                i_rd,             // Read strobe
  input wire logic [DATA_W-1:0]   o_rdata,          // Read data
  input wire logic [SAMPLE_W-1:0] o_bus_a,          // Bus A
  input wire logic [SAMPLE_W-1:0] o_bus_b,          // Bus B
  input wire logic [SAMPLE_W-1:0] o_bus_c,          // Bus C
  input wire logic [SAMPLE_W-1:0] o_bus_d,          // Bus D
  input wire logic [3:0]          o_bus_active,     // Powered buses
  input wire logic                o_strobe,         // Frame strobe
  input wire logic                o_clk_enable,     // Clock gate
  input wire logic                o_single_channel  // Interleave
);
  logic [7:0] ctl_q;
  logic [7:0] en_q;
  logic [7:0] mode_q;
  logic [7:0] rexp_q;

  function automatic logic [11:0] keep(input logic [1:0] w);
    case (w)
      WIDTH_11: return 12'hffe;
      WIDTH_10: return 12'hffc;
      WIDTH_8:  return 12'hff0;
      default:  return 12'hfff;
    endcase
  endfunction

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctl_q <= 8'h1e;
      en_q <= 8'h01;
      mode_q <= 8'h01;
    end else if (i_wr) begin
      if (i_addr == PATTERN_CONTROL_OFS) ctl_q <= i_wdata;
      if (i_addr == OUT_IF_ENABLE_OFS) en_q <= i_wdata;
      if (i_addr == OUT_IF_MODE_OFS) mode_q <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) rexp_q <= 8'h00;
    else if (!i_rd) rexp_q <= 8'h00;
    else if (i_addr == PATTERN_CONTROL_OFS) rexp_q <= ctl_q;
    else if (i_addr == OUT_IF_ENABLE_OFS) rexp_q <= en_q;
    else if (i_addr == OUT_IF_MODE_OFS) rexp_q <= mode_q;
    else rexp_q <= 8'h00;
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  chk_read_data: assert property (o_rdata == rexp_q)
    else $error("read data differs from register");
  chk_disable_clears: assert property (i_wr && i_addr == OUT_IF_ENABLE_OFS
    && !i_wdata[ENABLE_BIT] |-> ##2 !o_clk_enable && o_bus_active == 4'h0)
    else $error("interface not shut after disable");
  chk_enable_wakes: assert property (i_wr && i_addr == OUT_IF_ENABLE_OFS
    && i_wdata[ENABLE_BIT] |-> ##2 o_clk_enable)
    else $error("interface not woken after enable");
  chk_idle_quiet: assert property (!o_clk_enable && !$past(o_clk_enable) |->
    {o_bus_a, o_bus_b, o_bus_c, o_bus_d} == 48'h0 && !o_strobe)
    else $error("outputs active while disabled");
  chk_active_buses: assert property (o_clk_enable && en_q[ENABLE_BIT] |->
    o_bus_active == (mode_q[DEMUX_BIT] ? 4'hf : 4'h3))
    else $error("wrong set of powered buses");
  chk_single_mode: assert property (o_single_channel == mode_q[INTERLEAVE_BIT])
    else $error("interleave output differs from mode");
  chk_width_mask: assert property (!$stable({o_bus_a, o_bus_b}) |->
    ((o_bus_a | o_bus_b) & ~keep($past(mode_q[5:4]))) == 12'h000)
    else $error("low bits not cleared for width");
  chk_ui_single: assert property ($rose(o_strobe) && !mode_q[DEMUX_BIT] |->
    o_strobe[*6] ##[1:4] !o_strobe)
    else $error("strobe length wrong for demux one");
  chk_ui_double: assert property ($rose(o_strobe) && mode_q[DEMUX_BIT] |->
    o_strobe[*8] ##1 o_strobe[*6] ##[1:4] !o_strobe)
    else $error("strobe length wrong for demux two");
endmodule

bind lvdsoc_regs lvdsoc_regs_assertions lvdsoc_regs_assertions_inst (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_bus_a(o_bus_a), .o_bus_b(o_bus_b),
  .o_bus_c(o_bus_c), .o_bus_d(o_bus_d), .o_bus_active(o_bus_active),
  .o_strobe(o_strobe), .o_clk_enable(o_clk_enable), .o_single_channel(o_single_channel)
);
`default_nettype wire

/* File: lvdsoc_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lvdsoc_regs_tb_top;
  import lvdsoc_pkg::*;
  logic                  i_mclk = 1'b0;
  logic                  i_reset_n = 1'b0;
  logic [ADDR_W-1:0]     i_addr = '0;
  logic [DATA_W-1:0]     i_wdata = '0;
  logic                  i_wr = 1'b0;
  logic                  i_rd = 1'b0;
  logic                  i_user_test_pattern_select = 1'b1;
  logic [8*SAMPLE_W-1:0] i_user_pattern_sample = '0;
  logic [SAMPLE_W-1:0]   i_sample_ch0 = '0;
  logic [SAMPLE_W-1:0]   i_sample_ch1 = '0;
  logic                  run = 1'b0;
  logic                  sref_req = 1'b0;
  logic                  link_clk, sysref, o_strobe, o_clk_enable, o_single_channel;
  logic [DATA_W-1:0]     o_rdata;
  logic [SAMPLE_W-1:0]   o_bus_a, o_bus_b, o_bus_c, o_bus_d;
  logic [SAMPLE_W-1:0]   ga [4], gb [4], gc [4], gd [4];
  logic [3:0]            o_bus_active;
  logic [31:0]           r;
  logic [7:0]            c, m;
  int                    seed = 13227;
  int                    n_fail = 0;
  int                    n_tests = 0;

  lvdsoc_regs lvdsoc_regs_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_link_clk(link_clk),
    .i_sysref(sysref), .i_user_test_pattern_select(i_user_test_pattern_select),
    .i_user_pattern_sample(i_user_pattern_sample), .i_sample_ch0(i_sample_ch0),
    .i_sample_ch1(i_sample_ch1), .o_bus_a(o_bus_a), .o_bus_b(o_bus_b), .o_bus_c(o_bus_c),
    .o_bus_d(o_bus_d), .o_bus_active(o_bus_active), .o_strobe(o_strobe),
    .o_clk_enable(o_clk_enable), .o_single_channel(o_single_channel));
  lvdsoc_rx_model lvdsoc_rx_model_inst (.i_run(run), .i_sysref_req(sref_req),
    .o_link_clk(link_clk), .o_sysref(sysref));

  always #25 i_mclk = ~i_mclk;

  task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    r = $random(seed);
    i_sample_ch0 <= r[11:0];
    i_sample_ch1 <= r[23:12];
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", {4'h0, o_rdata}, {4'h0, e});
  endtask

  task automatic waitev(input int lim, input bit strb);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge i_mclk);
      #1;
      if (strb ? (o_strobe === 1'b1) : (o_bus_a !== 12'h000)) break;
    end
    if (i == lim) begin
      n_fail++;
      $display("Error wait expected event %0d seen timeout", strb);
      print_verdict();
    end
  endtask

  // Expected pattern sample on one bus, after inversion and width masking
  function automatic logic [11:0] ex(input int i, input int bus);
    logic [11:0] s;
    logic [7:0]  lane;
    lane = 8'he2;
    s = c[FIXED_LANE_BIT] ? {12{lane[i]}} : i_user_pattern_sample[12*i +: 12];
    s[8+bus] = s[8+bus] ^ c[bus];
    case (m[5:4])
      2'h1: s[0] = 1'b0;
      2'h2: s[1:0] = 2'h0;
      2'h3: s[3:0] = 4'h0;
      default: ;
    endcase
    return s;
  endfunction

  task automatic pat_run(input int t);
    int ui;
    int i0;
    logic ok, hit;
    ui = m[DEMUX_BIT] ? 16 : 8;
    wr(OUT_IF_ENABLE_OFS, 8'h00);
    wr(PATTERN_CONTROL_OFS, c);
    wr(OUT_IF_MODE_OFS, m);
    rd(PATTERN_CONTROL_OFS, c);
    rd(OUT_IF_MODE_OFS, m);
    wr(OUT_IF_ENABLE_OFS, 8'h01);
    run <= 1'b1;
    waitev(400, 1'b0);
    repeat (ui / 2) @(posedge i_mclk);
    for (int j = 0; j < 4; j++) begin
      ga[j] = o_bus_a;
      gb[j] = o_bus_b;
      gc[j] = o_bus_c;
      gd[j] = o_bus_d;
      repeat (ui) @(posedge i_mclk);
    end
    hit = 1'b0;
    for (int k = 0; k < 8; k++) begin
      ok = 1'b1;
      for (int j = 0; j < 4; j++) begin
        i0 = (j * (m[DEMUX_BIT] ? 2 : 1) + k) % 8;
        ok &= (ga[j] === ex(i0, 0)) && (gb[j] === ex(i0, 1));
        if (m[DEMUX_BIT]) ok &= (gc[j] === ex((i0 + 1) % 8, 2)) && (gd[j] === ex((i0 + 1) % 8, 3));
      end
      hit |= ok;
    end
    chk("pattern", {11'h000, hit}, 12'h001);
    $display("Test pattern %0d done", t);
  endtask

  initial begin
    repeat (10) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rd(PATTERN_CONTROL_OFS, 8'h1e);
    rd(OUT_IF_ENABLE_OFS, 8'h01);
    rd(OUT_IF_MODE_OFS, 8'h01);
    rd(12'h0202, 8'h00);
    $display("Test reset_values done");
    for (int t = 0; t < 6; t++) begin
      r = $random(seed);
      c = r[7:0];
      m = r[15:8];
      if (t == 0) c[FIXED_LANE_BIT] = 1'b1;
      if (t == 0) m[DEMUX_BIT] = 1'b0;
      c[0] = c[0] | c[FIXED_LANE_BIT];
      m[ALIGN_BIT] = m[ALIGN_BIT] | m[DEMUX_BIT];
      for (int k = 0; k < 8; k++) begin
        r = $random(seed);
        i_user_pattern_sample[12*k +: 12] <= r[11:0] | 12'h010;
      end
      pat_run(t);
    end
    sref_req <= 1'b1;
    repeat (20) @(posedge i_mclk);
    sref_req <= 1'b0;
    waitev(3000, 1'b1);
    chk("strobe", {11'h000, o_strobe}, 12'h001);
    repeat (40) @(posedge i_mclk);
    $display("Test strobe done");
    i_user_test_pattern_select <= 1'b0;
    wr(OUT_IF_ENABLE_OFS, 8'h00);
    wr(OUT_IF_MODE_OFS, 8'h05);
    wr(OUT_IF_ENABLE_OFS, 8'h01);
    i_sample_ch0 <= 12'h5a3;
    i_sample_ch1 <= 12'ha5c;
    repeat (200) @(posedge i_mclk);
    #1;
    chk("data_a", o_bus_a, 12'h5a3);
    chk("data_b", o_bus_b, 12'h5a3);
    chk("data_c", o_bus_c, 12'h5a3);
    chk("data_d", o_bus_d, 12'h5a3);
    chk("single", {11'h000, o_single_channel}, 12'h001);
    $display("Test data_mode done");
    wr(OUT_IF_ENABLE_OFS, 8'h00);
    sref_req <= 1'b1;
    repeat (20) @(posedge i_mclk);
    sref_req <= 1'b0;
    repeat (300) @(posedge i_mclk);
    #1;
    chk("bus_active", {8'h00, o_bus_active}, 12'h000);
    chk("clk_enable", {11'h000, o_clk_enable}, 12'h000);
    chk("strobe_off", {11'h000, o_strobe}, 12'h000);
    run <= 1'b0;
    $display("Test disable done");
    print_verdict();
  end
endmodule
`default_nettype wire
